// file: src/led_sink_pkg.sv
package led_sink_pkg;

  // ==========================================
  // clock and detection timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int DET_TIME_NS   = 700;
  localparam int DET_CYCLES    = (DET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] DET_LAST = 4'(DET_CYCLES - 1);

  // ==========================================
  // command codes: clock edges seen while strobe is high
  localparam logic [3:0] CMD_LATCH    = 4'h0;
  localparam logic [3:0] CMD_OPEN     = 4'h1;
  localparam logic [3:0] CMD_SHORT    = 4'h2;
  localparam logic [3:0] CMD_THERMAL  = 4'h3;
  localparam logic [3:0] CMD_WRITE    = 4'h4;
  localparam logic [3:0] CMD_LEAK     = 4'h5;
  localparam logic [3:0] CMD_READ     = 4'h6;
  localparam logic [3:0] CMD_WAKE     = 4'h7;
  localparam logic [3:0] CMD_ARM      = 4'h8;
  localparam logic [3:0] CMD_SLEEP    = 4'h9;
  localparam logic [3:0] CMD_NONE     = 4'ha;

  // ==========================================
  // driver_configuration layout
  localparam int CFG_THR_LSB  = 14;
  localparam int CFG_ZERO     = 13;
  localparam int CFG_SLEEP    = 12;
  localparam int CFG_CUR_LSB  = 10;
  localparam int CFG_DET_TIME = 9;
  localparam logic [15:0] CFG_RESET = 16'hc800;
  localparam logic [15:0] CFG_MASK  = 16'hfe00;

  // ==========================================
  // other widths and reset values
  localparam int CH_COUNT   = 16;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [15:0] ALL_OK = 16'hffff;

  typedef enum logic [1:0] {
    DET_IDLE,
    DET_OS,
    DET_LEAK
  } det_state_t;

endpackage : led_sink_pkg

// file: src/led_sink_serial_command_port.sv
`timescale 1ns/10ps

// ==========================================
// result fifo
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } fifo_state_t;

  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic        push;
  logic        pop;

  assign in_ready  = (s_reg.cnt != CW'(DEPTH));
  assign out_valid = (s_reg.cnt != '0);
  assign out_data  = s_reg.mem[s_reg.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr] = in_data;
      s_next.wr = PW'(s_reg.wr + 1'b1);
    end
    if (pop) begin
      s_next.rd = PW'(s_reg.rd + 1'b1);
    end
    if (push && !pop) begin
      s_next.cnt = CW'(s_reg.cnt + 1'b1);
    end else if (pop && !push) begin
      s_next.cnt = CW'(s_reg.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : result_fifo

// How it works
// - each serial clock rise shifts serial_in into 16-bit register; msb goes out
// - strobe with no clock edges copies shift register into output latch
// - channel sinks with output gate low and its latch bit one; every channel sinks during open or short detection
// - edges counted while strobe high pick command at strobe fall; ten or more ignored
// - one edge starts open-circuit detection on all channels
// - two edges start short-circuit detection on all channels
// - three edges start the over-temperature check
// - open and short share one detection run; five edges start leakage diagnosis
// - four edges load shift register into configuration when armed
// - six edges put configuration on serial output, bit 15 first
// - seven edges wake from sleep or zero-power; config bit D enables zero-power
// - eight edges arm the configuration for the next write
// - nine edges enter sleep only when config bit C is one
// - config bits F:E pick the shared short and leakage threshold, default 11
// - config bits B:A pick detection current, default 10
// - bit 9 low: open or short detection lasts a fixed 700 ns
// - bit 9 high: detection ends at rising edge of output gate
// - bit 9 timing applies to open and short only
// - error flag is 0 for a faulty channel, 1 otherwise
// - an invalid detection leaves every flag at 1
// - results overwrite the shift register at detection end, then shift out
module led_sink_serial_command_port (
  // clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 nrst,
  // serial pins
  input  wire logic                                 serial_clk,
  input  wire logic                                 serial_in,
  input  wire logic                                 latch_strobe,
  input  wire logic                                 out_gate_n,
  output logic                                      serial_out,
  // channel drive
  output logic [led_sink_pkg::CH_COUNT-1:0]         sink_channel,
  output logic                                      detect_on,
  output logic                                      leak_check,
  output logic [1:0]                                detect_current,
  output logic [1:0]                                short_threshold,
  output logic [1:0]                                leakage_threshold,
  // comparator results
  input  wire logic [led_sink_pkg::CH_COUNT-1:0]    channel_fault,
  input  wire logic                                 over_temp,
  // power state
  output logic                                      sleep_mode,
  output logic                                      zero_power,
  // detection result stream
  output logic                                      result_valid,
  input  wire logic                                 result_ready,
  output logic [led_sink_pkg::FIFO_WIDTH-1:0]       result_data
);
  import led_sink_pkg::*;

  typedef struct packed {
    logic        sclk_s1;
    logic        sclk_s2;
    logic        sclk_s3;
    logic        sdi_s1;
    logic        sdi_s2;
    logic        le_s1;
    logic        le_s2;
    logic        le_s3;
    logic        oe_s1;
    logic        oe_s2;
    logic        oe_s3;
    logic [15:0] flt_s1;
    logic [15:0] flt_s2;
    logic        tmp_s1;
    logic        tmp_s2;
    logic [15:0] shift;
    logic [15:0] latch;
    logic [15:0] cfg;
    logic [3:0]  edges;
    logic        armed;
    logic        sleep;
    logic        zero;
    det_state_t  det;
    logic [3:0]  dcnt;
    logic        dvalid;
    logic        push;
    logic [15:0] push_data;
    logic [15:0] sink;
  } port_state_t;

  port_state_t s_reg;
  port_state_t s_next;
  logic        rise;
  logic        le_fall;
  logic        oe_rise;
  logic        det_end;
  logic        fifo_ready;

  assign rise    = s_reg.sclk_s2 && !s_reg.sclk_s3;
  assign le_fall = !s_reg.le_s2 && s_reg.le_s3;
  assign oe_rise = s_reg.oe_s2 && !s_reg.oe_s3;

  // ==========================================
  // detection end
  always_comb begin
    det_end = 1'b0;
    if (s_reg.det == DET_OS) begin
      det_end = s_reg.cfg[CFG_DET_TIME] ? oe_rise : (s_reg.dcnt == DET_LAST);
    end else if (s_reg.det == DET_LEAK) begin
      det_end = (s_reg.dcnt == DET_LAST);
    end
  end

  // ==========================================
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.push = 1'b0;
    s_next.sclk_s1 = serial_clk;
    s_next.sclk_s2 = s_reg.sclk_s1;
    s_next.sclk_s3 = s_reg.sclk_s2;
    s_next.sdi_s1 = serial_in;
    s_next.sdi_s2 = s_reg.sdi_s1;
    s_next.le_s1 = latch_strobe;
    s_next.le_s2 = s_reg.le_s1;
    s_next.le_s3 = s_reg.le_s2;
    s_next.oe_s1 = out_gate_n;
    s_next.oe_s2 = s_reg.oe_s1;
    s_next.oe_s3 = s_reg.oe_s2;
    s_next.flt_s1 = channel_fault;
    s_next.flt_s2 = s_reg.flt_s1;
    s_next.tmp_s1 = over_temp;
    s_next.tmp_s2 = s_reg.tmp_s1;
    if (rise) begin
      s_next.shift = {s_reg.shift[14:0], s_reg.sdi_s2};
      if (s_reg.le_s2 && s_reg.edges != CMD_NONE) begin
        s_next.edges = s_reg.edges + 4'h1;
      end
    end
    if (le_fall) begin
      s_next.edges = CMD_LATCH;
      unique case (s_reg.edges)
        CMD_LATCH: begin
          s_next.latch = s_reg.shift;
          if (s_reg.cfg[CFG_ZERO] && s_reg.shift == '0) begin
            s_next.zero = 1'b1;
          end
        end
        CMD_OPEN, CMD_SHORT: begin
          if (s_reg.det == DET_IDLE && fifo_ready) begin
            s_next.det = DET_OS;
            s_next.dcnt = '0;
          end
        end
        CMD_THERMAL: begin
          s_next.shift = {16{!s_reg.tmp_s2}};
        end
        CMD_WRITE: begin
          if (s_reg.armed) begin
            s_next.cfg = s_reg.shift & CFG_MASK;
            s_next.armed = 1'b0;
          end
        end
        CMD_LEAK: begin
          if (s_reg.det == DET_IDLE && fifo_ready) begin
            s_next.det = DET_LEAK;
            s_next.dcnt = '0;
            s_next.dvalid = s_reg.oe_s2;
          end
        end
        CMD_READ: begin
          s_next.shift = s_reg.cfg;
        end
        CMD_WAKE: begin
          s_next.sleep = 1'b0;
          s_next.zero = 1'b0;
        end
        CMD_ARM: begin
          s_next.armed = 1'b1;
        end
        CMD_SLEEP: begin
          if (s_reg.cfg[CFG_SLEEP]) begin
            s_next.sleep = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (s_reg.det != DET_IDLE) begin
      if (s_reg.dcnt != 4'hf) begin
        s_next.dcnt = s_reg.dcnt + 4'h1;
      end
      if (s_reg.det == DET_LEAK && !s_reg.oe_s2) begin
        s_next.dvalid = 1'b0;
      end
    end
    if (det_end) begin
      s_next.det = DET_IDLE;
      if (s_reg.det == DET_LEAK && !s_reg.dvalid) begin
        s_next.shift = ALL_OK;
      end else begin
        s_next.shift = ~s_reg.flt_s2;
      end
      s_next.push = 1'b1;
      s_next.push_data = s_next.shift;
    end
    if (s_reg.det == DET_OS) begin
      s_next.sink = ALL_OK;
    end else if (s_reg.det == DET_LEAK || s_reg.oe_s2 || s_reg.sleep || s_reg.zero) begin
      s_next.sink = '0;
    end else begin
      s_next.sink = s_reg.latch;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.cfg <= CFG_RESET;
      s_reg.det <= DET_IDLE;
      s_reg.oe_s1 <= 1'b1;
      s_reg.oe_s2 <= 1'b1;
      s_reg.oe_s3 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================
  // outputs
  assign serial_out        = s_reg.shift[15];
  assign sink_channel      = s_reg.sink;
  assign detect_on         = (s_reg.det == DET_OS);
  assign leak_check        = (s_reg.det == DET_LEAK);
  assign detect_current    = s_reg.cfg[CFG_CUR_LSB +: 2];
  assign short_threshold   = s_reg.cfg[CFG_THR_LSB +: 2];
  assign leakage_threshold = s_reg.cfg[CFG_THR_LSB +: 2];
  assign sleep_mode        = s_reg.sleep;
  assign zero_power        = s_reg.zero;

  result_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (s_reg.push),
    .in_ready  (fifo_ready),
    .in_data   (s_reg.push_data),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (result_data)
  );

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  shift_in_a: assert property (
    rise && !le_fall && s_reg.det == DET_IDLE |=>
      s_reg.shift == {$past(s_reg.shift[14:0]), $past(s_reg.sdi_s2)})
    else $error("shift register did not take serial bit");

  latch_copy_a: assert property (
    le_fall && s_reg.edges == CMD_LATCH |=> s_reg.latch == $past(s_reg.shift))
    else $error("latch not loaded on zero-edge strobe");

  channel_drive_a: assert property (
    s_reg.det == DET_IDLE && !s_reg.oe_s2 && !s_reg.sleep && !s_reg.zero
      |=> sink_channel == $past(s_reg.latch))
    else $error("channel drive does not follow latch");

  no_action_a: assert property (
    le_fall && s_reg.edges == CMD_NONE |=> $stable(s_reg.cfg) && $stable(s_reg.latch))
    else $error("ten or more edges changed state");

  open_start_a: assert property (
    le_fall && s_reg.edges == CMD_OPEN && s_reg.det == DET_IDLE && fifo_ready
      |=> detect_on ##1 detect_on)
    else $error("open detection not started");

  short_start_a: assert property (
    le_fall && s_reg.edges == CMD_SHORT && s_reg.det == DET_IDLE && fifo_ready
      |=> detect_on ##1 sink_channel == ALL_OK)
    else $error("short detection not started");

  thermal_load_a: assert property (
    le_fall && s_reg.edges == CMD_THERMAL && !det_end
      |=> s_reg.shift == {16{!$past(s_reg.tmp_s2)}})
    else $error("thermal flag not loaded");

  leak_start_a: assert property (
    le_fall && s_reg.edges == CMD_LEAK && s_reg.det == DET_IDLE && fifo_ready
      |=> leak_check && !detect_on)
    else $error("leakage diagnosis not started");

  cfg_write_a: assert property (
    le_fall && s_reg.edges == CMD_WRITE && s_reg.armed
      |=> s_reg.cfg == ($past(s_reg.shift) & CFG_MASK) && !s_reg.armed)
    else $error("armed write did not load configuration");

  cfg_read_a: assert property (
    le_fall && s_reg.edges == CMD_READ && !det_end |=> serial_out == s_reg.cfg[15])
    else $error("readback did not present bit 15");

  wake_up_a: assert property (
    le_fall && s_reg.edges == CMD_WAKE |=> !sleep_mode && !zero_power)
    else $error("wake command did not clear power state");

  arm_write_a: assert property (
    le_fall && s_reg.edges == CMD_ARM |=> s_reg.armed)
    else $error("write not armed");

  sleep_enter_a: assert property (
    le_fall && s_reg.edges == CMD_SLEEP && !s_reg.sleep |=> sleep_mode == $past(s_reg.cfg[CFG_SLEEP]))
    else $error("sleep entry wrong");

  fixed_time_a: assert property (
    detect_on && !s_reg.cfg[CFG_DET_TIME] && s_reg.dcnt < DET_LAST |=> detect_on)
    else $error("fixed detection ended early");

  fixed_end_a: assert property (
    detect_on && !s_reg.cfg[CFG_DET_TIME] && s_reg.dcnt == DET_LAST |=> !detect_on)
    else $error("fixed detection did not end on time");

  gate_end_a: assert property (
    detect_on && s_reg.cfg[CFG_DET_TIME] |-> det_end == oe_rise)
    else $error("gated detection end wrong");

  result_load_a: assert property (
    det_end && s_reg.det == DET_OS |=> s_reg.shift == ~$past(s_reg.flt_s2) ##1 result_valid)
    else $error("detection result not loaded");

  invalid_leak_a: assert property (
    det_end && s_reg.det == DET_LEAK && !s_reg.dvalid |=> s_reg.shift == ALL_OK)
    else $error("invalid leakage run changed flags");

endmodule : led_sink_serial_command_port

// file: bench/display_controller_model.sv
`timescale 1ns/10ps

// ==========================================
// serial controller model
module display_controller_model (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      serial_clk,
  output logic      serial_in,
  output logic      latch_strobe,
  input  wire logic serial_out
);
  initial begin
    serial_clk   = 1'b0;
    serial_in    = 1'b0;
    latch_strobe = 1'b0;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // shift a word msb first, last n rises inside the strobe
  task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      serial_clk = 1'b0;
      serial_in  = w[i];
      if (i == n - 1) latch_strobe = 1'b1;
      tick(3);
      r[i]       = serial_out;
      serial_clk = 1'b1;
      tick(3);
    end
    serial_clk   = 1'b0;
    serial_in    = ~w[0];
    latch_strobe = 1'b1;
    tick(3);
    latch_strobe = 1'b0;
    tick(1);
  endtask : frame
endmodule : display_controller_model

// file: bench/testbench.sv
`timescale 1ns/10ps

// ==========================================
// testbench
module testbench;
  import led_sink_pkg::*;
  logic        clk, nrst, out_gate_n, over_temp, result_ready;
  logic        serial_clk, serial_in, latch_strobe, serial_out;
  logic        sleep_mode, zero_power, result_valid, detect_on, leak_check;
  logic [1:0]  detect_current, short_threshold, leakage_threshold;
  logic [15:0] sink_channel, channel_fault, result_data, w, v, r;
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;
  int          dc, k;

  initial clk = 1'b0;
  always #25 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      test_done();
    end
  end

  led_sink_serial_command_port uut (.clk(clk), .nrst(nrst), .serial_clk(serial_clk),
    .serial_in(serial_in), .latch_strobe(latch_strobe), .out_gate_n(out_gate_n),
    .serial_out(serial_out), .sink_channel(sink_channel), .detect_on(detect_on),
    .leak_check(leak_check), .detect_current(detect_current), .short_threshold(short_threshold),
    .leakage_threshold(leakage_threshold), .channel_fault(channel_fault), .over_temp(over_temp),
    .sleep_mode(sleep_mode), .zero_power(zero_power), .result_valid(result_valid),
    .result_ready(result_ready), .result_data(result_data));

  display_controller_model ctl (.clk(clk), .serial_clk(serial_clk), .serial_in(serial_in),
    .latch_strobe(latch_strobe), .serial_out(serial_out));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_end(input string s);
    $display("test %s finished", s);
  endtask : test_end

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic read_cfg(output logic [15:0] c);
    logic [15:0] t;
    ctl.frame(16'h0000, 6, t);
    ctl.frame(16'h0000, 10, c);
  endtask : read_cfg

  task automatic write_cfg(input logic [15:0] c);
    logic [15:0] t;
    ctl.frame(16'h0000, 8, t);
    ctl.frame(c, 4, t);
  endtask : write_cfg

  // run one detection, time it, pop and shift out its word
  task automatic detect(input int n, input logic [15:0] exp);
    logic [15:0] t;
    ctl.frame(16'h0000, n, t);
    dc = 0;
    for (k = 0; k < 100 && result_valid !== 1'b1; k++) begin
      if (detect_on === 1'b1 || leak_check === 1'b1) dc++;
      ctl.tick(1);
    end
    check(16'(dc), 16'(DET_CYCLES));
    check(result_data, exp);
    result_ready = 1'b1;
    ctl.tick(1);
    result_ready = 1'b0;
    ctl.frame(16'h0000, 10, t);
    check(t, exp);
  endtask : detect

  initial begin
    nrst          = 1'b0;
    out_gate_n    = 1'b1;
    over_temp     = 1'b0;
    result_ready  = 1'b0;
    channel_fault = 16'h0000;
    k = $urandom(93892);
    ctl.tick(5);
    nrst = 1'b1;
    ctl.tick(1);
    check(16'(detect_current), 16'h0002);
    check(16'({short_threshold, leakage_threshold}), 16'h000f);
    check(16'({sleep_mode, zero_power, result_valid}), 16'h0000);
    read_cfg(r);
    check(r, CFG_RESET);
    test_end("reset");
    w = 16'($urandom);
    out_gate_n = 1'b0;
    ctl.frame(w, 0, r);
    ctl.tick(4);
    check(sink_channel, w);
    out_gate_n = 1'b1;
    ctl.tick(4);
    check(sink_channel, 16'h0000);
    out_gate_n = 1'b0;
    ctl.frame(~w, 10, r);
    ctl.tick(4);
    check(sink_channel, w);
    check(r, w);
    test_end("latch");
    v = 16'($urandom) & 16'hcdff | 16'h0800;
    ctl.frame(v, 4, r);
    read_cfg(r);
    check(r, CFG_RESET);
    write_cfg(v);
    read_cfg(r);
    check(r, v & CFG_MASK);
    check(16'({short_threshold, leakage_threshold, detect_current}),
          16'({v[15:14], v[15:14], v[11:10]}));
    test_end("config");
    for (int i = 0; i < 3; i++) begin
      channel_fault = 16'($urandom);
      out_gate_n = (i == 2) ? 1'b1 : 1'($urandom);
      detect((i == 2) ? 5 : i + 1, ~channel_fault);
    end
    out_gate_n = 1'b0;
    detect(5, ALL_OK);
    test_end("detect");
    for (int i = 0; i < 2; i++) begin
      over_temp = i[0];
      ctl.frame(16'h0000, 3, r);
      ctl.frame(16'h0000, 10, r);
      check(r, {16{~over_temp}});
    end
    test_end("thermal");
    ctl.frame(16'h0000, 9, r);
    ctl.tick(4);
    check(16'(sleep_mode), 16'h0000);
    write_cfg(v | 16'h1000);
    ctl.frame(16'h0000, 9, r);
    ctl.tick(4);
    check(16'(sleep_mode), 16'h0001);
    check(sink_channel, 16'h0000);
    ctl.frame(16'h0000, 7, r);
    ctl.tick(4);
    check(16'(sleep_mode), 16'h0000);
    check(sink_channel, w);
    test_end("sleep");
    write_cfg(v | 16'h2200);
    ctl.frame(16'h0000, 0, r);
    ctl.tick(4);
    check(16'(zero_power), 16'h0001);
    check(sink_channel, 16'h0000);
    ctl.frame(16'h0000, 7, r);
    ctl.tick(4);
    check(16'(zero_power), 16'h0000);
    channel_fault = 16'($urandom);
    out_gate_n = 1'b0;
    ctl.frame(16'h0000, 1, r);
    ctl.tick(40);
    check(16'(detect_on), 16'h0001);
    out_gate_n = 1'b1;
    ctl.tick(4);
    check(16'({detect_on, result_valid}), 16'h0001);
    check(result_data, ~channel_fault);
    result_ready = 1'b1;
    ctl.tick(1);
    result_ready = 1'b0;
    write_cfg(v);
    test_end("zero power and gated detection");
    result_ready = 1'b1;
    ctl.tick(2);
    result_ready = 1'b0;
    channel_fault = 16'($urandom);
    out_gate_n = 1'b1;
    for (int i = 0; i < 17; i++) begin
      ctl.frame(16'h0000, 1, r);
      ctl.tick(20);
    end
    dc = 0;
    for (k = 0; k < 400 && result_valid === 1'b1; k++) begin
      result_ready = 1'($urandom);
      if (result_ready) dc++;
      if (result_ready) check(result_data, ~channel_fault);
      ctl.tick(1);
    end
    result_ready = 1'b0;
    check(16'(dc), 16'(FIFO_DEPTH));
    test_end("fifo");
    test_done();
  end
endmodule : testbench
